// ==== rtl/rpx_bus_ctrl.sv ====
// expansion bus and management bus pin logic of the repeater controller
`default_nettype none
module rpx_bus_ctrl #(
  parameter int unsigned STATUS_BITS = rpx_pkg::STATUS_BITS,
  parameter int unsigned KEEP_BITS   = rpx_pkg::COMPRESS_KEEP_BITS,
  parameter int unsigned W           = rpx_pkg::LINK_WORD_BITS
) (
  input  wire logic                   sys_clk_i,
  input  wire logic                   rst_n_i,
  // own segment side, same clock domain
  input  wire logic                   seg_rx_active_i,
  input  wire logic                   seg_rx_bit_i,
  output logic                        seg_bit_take_o,
  input  wire logic                   seg_rx_collision_i,
  input  wire logic                   seg_multi_collision_i,
  input  wire logic                   seg_tx_collision_i,
  input  wire logic                   seg_raw_manchester_i,
  input  wire logic [STATUS_BITS-1:0] status_word_i,
  // expansion bus pins
  input  wire logic                   receiving_port_collision_i,
  output logic                        receiving_port_collision_o,
  output logic                        receiving_port_collision_oe_o,
  input  wire logic                   expansion_serial_data_i,
  output logic                        expansion_serial_data_o,
  output logic                        expansion_serial_data_oe_o,
  input  wire logic                   expansion_frame_enable_i,
  output logic                        expansion_frame_enable_o,
  output logic                        expansion_frame_enable_oe_o,
  input  wire logic                   expansion_bus_clock_i,
  output logic                        expansion_bus_clock_o,
  output logic                        expansion_bus_clock_oe_o,
  output logic                        expansion_bus_drive_enable_o,
  // activity lines, open drain, active low on the wire
  output logic                        local_activity_drive_o,
  output logic                        local_activity_drive_oe_o,
  input  wire logic                   local_activity_sense_n_i,
  output logic                        other_activity_drive_o,
  output logic                        other_activity_drive_oe_o,
  input  wire logic                   other_activity_sense_n_i,
  // management bus pins
  output logic                        mgmt_rx_clock_o,
  output logic                        mgmt_rx_clock_oe_o,
  input  wire logic                   mgmt_carrier_sense_i,
  output logic                        mgmt_carrier_sense_o,
  output logic                        mgmt_carrier_sense_oe_o,
  output logic                        mgmt_rx_data_o,
  output logic                        mgmt_rx_data_oe_o,
  output logic                        mgmt_bus_drive_enable_o,
  input  wire logic                   packet_shorten_request_n_i,
  output logic                        raw_encoded_rx_test_out_o,
  // sensed state for the rest of the chip
  output logic                        local_activity_seen_o,
  output logic                        other_activity_seen_o,
  output logic                        bus_collision_seen_o,
  output logic                        mgmt_carrier_seen_o,
  output logic                        packet_compressed_o,
  output logic                        exp_rx_frame_o,
  output logic [W-1:0]                exp_rx_word_o,
  output logic                        exp_rx_word_valid_o
);
  localparam int unsigned SCW = $clog2(STATUS_BITS);
  localparam int unsigned PCW = $clog2(KEEP_BITS + 1);

  typedef struct packed {
    rpx_pkg::rpx_state_e  state;
    logic                 phase;
    logic                 data;
    logic                 col;
    logic                 act;
    logic                 xcol;
    logic                 raw;
    logic                 compress;
    logic                 mute;
    logic [PCW-1:0]       pkt_cnt;
    logic [SCW-1:0]       stat_cnt;
    logic [STATUS_BITS-1:0] stat_sh;
    logic [1:0]           act_sy;
    logic [1:0]           oth_sy;
    logic [1:0]           col_sy;
    logic [1:0]           frm_sy;
    logic [1:0]           shr_sy;
    logic [1:0]           crs_sy;
    logic [2:0]           tog_sy;
    logic [W-1:0]         rx_word;
    logic                 rx_valid;
  } rpx_main_s;

  rpx_main_s s;
  rpx_main_s next_s;
  logic      driving;
  logic      mgmt_on;
  logic      bit_edge;

  rpx_link_if #(.W(W)) link ();

  // bus receive side
  // own frames masked: the bus clock is then our phase, so no echo count lingers
  rpx_link_rx #(.W(W)) u_link_rx (
    .link_clk_i (expansion_bus_clock_i),
    .rst_n_i    (rst_n_i),
    .frame_i    (expansion_frame_enable_i & ~driving),
    .data_i     (expansion_serial_data_i),
    .link       (link.rx)
  );

  assign driving  = (s.state == rpx_pkg::RPX_PACKET);
  assign mgmt_on  = (s.state != rpx_pkg::RPX_IDLE);
  // falling edge of the bit clock comes next cycle
  assign bit_edge = s.phase;

  // next bit wanted at frame start and at each falling edge while receiving
  assign seg_bit_take_o = seg_rx_active_i &&
                          ((s.state == rpx_pkg::RPX_IDLE) || (driving && bit_edge));

  // one state update; synchroniser chains only shift, nothing else reads stage one
  always_comb begin
    next_s          = s;
    next_s.act_sy   = {s.act_sy[0], ~local_activity_sense_n_i};
    next_s.oth_sy   = {s.oth_sy[0], ~other_activity_sense_n_i};
    next_s.col_sy   = {s.col_sy[0], receiving_port_collision_i};
    next_s.frm_sy   = {s.frm_sy[0], expansion_frame_enable_i};
    next_s.shr_sy   = {s.shr_sy[0], packet_shorten_request_n_i};
    next_s.crs_sy   = {s.crs_sy[0], mgmt_carrier_sense_i};
    next_s.tog_sy   = {s.tog_sy[1:0], link.word_toggle};
    next_s.rx_valid = 1'b0;
    // activity flags, driven from the registered copies
    next_s.act      = seg_rx_active_i | seg_rx_collision_i;
    next_s.xcol     = seg_tx_collision_i | seg_multi_collision_i;
    next_s.col      = seg_rx_collision_i;
    next_s.raw      = seg_raw_manchester_i;
    // words from other chips only; our own echo is ignored
    if (s.tog_sy[2] != s.tog_sy[1] && !driving) begin
      next_s.rx_word  = link.word;
      next_s.rx_valid = 1'b1;
    end
    // shorten request sampled only while the packet is driven, not during the status tail
    if (driving && !s.shr_sy[1]) begin
      next_s.compress = 1'b1;
    end
    unique case (s.state)
      rpx_pkg::RPX_IDLE: begin
        next_s.phase    = 1'b0;
        next_s.compress = 1'b0;
        next_s.mute     = 1'b0;
        next_s.pkt_cnt  = '0;
        if (seg_rx_active_i) begin
          next_s.state = rpx_pkg::RPX_PACKET;
          next_s.data  = seg_rx_bit_i;
        end
      end
      rpx_pkg::RPX_PACKET: begin
        next_s.phase = ~s.phase;
        // data moves only as the clock falls
        if (bit_edge) begin
          if (s.pkt_cnt != PCW'(KEEP_BITS)) begin
            next_s.pkt_cnt = s.pkt_cnt + 1'b1;
          end
          if (next_s.compress && s.pkt_cnt >= PCW'(KEEP_BITS - 1)) begin
            next_s.mute = 1'b1;
          end
          if (seg_rx_active_i) begin
            next_s.data = seg_rx_bit_i;
          end else begin
            // packet ended, status follows on management only
            next_s.state    = rpx_pkg::RPX_STATUS;
            next_s.mute     = 1'b0;
            next_s.data     = status_word_i[STATUS_BITS-1];
            next_s.stat_sh  = status_word_i << 1;
            next_s.stat_cnt = SCW'(STATUS_BITS - 1);
          end
        end
      end
      rpx_pkg::RPX_STATUS: begin
        next_s.phase = ~s.phase;
        if (bit_edge) begin
          if (s.stat_cnt == '0) begin
            next_s.state = rpx_pkg::RPX_IDLE;
            next_s.data  = rpx_pkg::SERIAL_RESET;
          end else begin
            next_s.stat_cnt = s.stat_cnt - 1'b1;
            next_s.data     = s.stat_sh[STATUS_BITS-1];
            next_s.stat_sh  = s.stat_sh << 1;
          end
        end
      end
      default: begin
        next_s.state = rpx_pkg::RPX_IDLE;
      end
    endcase
  end

  // single register for all state
  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      s       <= '0;
      s.state <= rpx_pkg::RPX_IDLE;
    end else begin
      s <= next_s;
    end
  end

  assign expansion_bus_drive_enable_o  = driving;
  // expansion drivers only while the direction output is high
  assign expansion_serial_data_o       = s.data;
  assign expansion_serial_data_oe_o    = driving;
  assign expansion_frame_enable_o      = driving;
  assign expansion_frame_enable_oe_o   = driving;
  assign expansion_bus_clock_o         = s.phase;
  assign expansion_bus_clock_oe_o      = driving;
  // collision line is an input unless this chip drives the bus
  assign receiving_port_collision_o    = s.col;
  assign receiving_port_collision_oe_o = driving;

  // open drain: pull low when active, release otherwise
  assign local_activity_drive_o        = 1'b0;
  assign local_activity_drive_oe_o     = s.act;
  assign other_activity_drive_o        = 1'b0;
  assign other_activity_drive_oe_o     = s.xcol;

  // management lines share one enable
  // a compressed packet holds the clock low, so the party sees fewer bits
  assign mgmt_rx_clock_o         = s.phase & ~s.mute;
  assign mgmt_rx_clock_oe_o      = mgmt_on;
  assign mgmt_carrier_sense_o    = 1'b1;
  assign mgmt_carrier_sense_oe_o = mgmt_on;
  assign mgmt_rx_data_o          = s.data;
  assign mgmt_rx_data_oe_o       = mgmt_on;
  assign mgmt_bus_drive_enable_o = mgmt_on;

  assign raw_encoded_rx_test_out_o = s.raw;
  assign local_activity_seen_o     = s.act_sy[1];
  assign other_activity_seen_o     = s.oth_sy[1];
  assign bus_collision_seen_o      = s.col_sy[1] & ~driving;
  assign mgmt_carrier_seen_o       = s.crs_sy[1] & ~mgmt_on;
  assign packet_compressed_o       = s.compress;
  assign exp_rx_frame_o            = s.frm_sy[1] & ~driving;
  assign exp_rx_word_o             = s.rx_word;
  assign exp_rx_word_valid_o       = s.rx_valid;

  default clocking cb @(posedge sys_clk_i);
  endclocking
  default disable iff (!rst_n_i);

  sequence pkt_end_s;
    driving && bit_edge && !seg_rx_active_i;
  endsequence

  sequence frame_start_s;
    (s.state == rpx_pkg::RPX_IDLE) && seg_rx_active_i;
  endsequence

  // collision driven while the receiving port collides
  col_drive_a : assert property (driving && $past(driving) && $past(seg_rx_collision_i)
    |-> receiving_port_collision_o && receiving_port_collision_oe_o)
    else $error("collision not driven");

  // collision line released when not driving
  col_release_a : assert property (!expansion_bus_drive_enable_o
    |-> !receiving_port_collision_oe_o)
    else $error("collision driven while not bus driver");

  // direction rises one cycle after frame start
  dir_rise_a : assert property (frame_start_s |=> expansion_bus_drive_enable_o)
    else $error("direction output did not rise");

  // direction falls when the packet ends
  dir_fall_a : assert property (pkt_end_s |=> !expansion_bus_drive_enable_o)
    else $error("direction output did not fall");

  // local activity pulls the line the next cycle
  act_drive_a : assert property ((seg_rx_active_i || seg_rx_collision_i)
    |=> local_activity_drive_oe_o && !local_activity_drive_o)
    else $error("local activity not driven");

  xcol_drive_a : assert property ((seg_tx_collision_i || seg_multi_collision_i)
    |=> other_activity_drive_oe_o)
    else $error("other activity not driven");

  mclk_idle_a : assert property ((s.state == rpx_pkg::RPX_IDLE)
    |-> !mgmt_rx_clock_oe_o && !mgmt_rx_data_oe_o)
    else $error("management clock driven while idle");

  // management data moves only with a falling clock
  mdata_edge_a : assert property (mgmt_on && $past(mgmt_on) && $changed(mgmt_rx_data_o)
    |-> $fell(s.phase))
    else $error("management data changed off falling edge");

  // status tail lasts two cycles per status bit
  status_len_a : assert property (pkt_end_s |=> (s.state == rpx_pkg::RPX_STATUS) [*8]
    ##24 (s.state == rpx_pkg::RPX_STATUS) ##1 (s.state == rpx_pkg::RPX_IDLE))
    else $error("status tail length wrong");

  mgmt_en_match_a : assert property (mgmt_bus_drive_enable_o == mgmt_carrier_sense_oe_o
    && mgmt_bus_drive_enable_o == mgmt_rx_clock_oe_o)
    else $error("management enable mismatch");

  // a low shorten request during a packet compresses it
  compress_a : assert property (driving && !s.shr_sy[1] |=> packet_compressed_o)
    else $error("packet not compressed");

  // raw test output copies the encoded stream
  raw_copy_a : assert property (##1 raw_encoded_rx_test_out_o
    == $past(seg_raw_manchester_i))
    else $error("raw test output wrong");

  exp_release_a : assert property (!expansion_bus_drive_enable_o
    |-> !(expansion_serial_data_oe_o || expansion_frame_enable_oe_o
    || expansion_bus_clock_oe_o))
    else $error("expansion driver on with direction low");

  act_release_a : assert property (!seg_rx_active_i && !seg_rx_collision_i
    |=> !local_activity_drive_oe_o)
    else $error("local activity held without cause");

  status_first_a : assert property (pkt_end_s
    |=> mgmt_rx_data_o == $past(status_word_i[STATUS_BITS-1]))
    else $error("status msb not first");

  crs_drive_a : assert property (frame_start_s
    |=> mgmt_carrier_sense_oe_o && mgmt_carrier_sense_o)
    else $error("carrier sense not driven");

  no_compress_a : assert property (driving && s.shr_sy[1] && !packet_compressed_o
    |=> !packet_compressed_o)
    else $error("packet compressed without request");

  exp_data_hold_a : assert property (driving && !bit_edge
    |=> $stable(expansion_serial_data_o))
    else $error("expansion data moved off falling edge");

  frame_drive_a : assert property (frame_start_s |=> expansion_frame_enable_oe_o
    && expansion_frame_enable_o && expansion_serial_data_oe_o
    && expansion_bus_clock_oe_o)
    else $error("expansion lines not driven");
endmodule : rpx_bus_ctrl
`default_nettype wire

// ==== rtl/rpx_pkg.sv ====
// package of constants and types for the repeater expansion and management bus block
// Contract
// - while driving the bus, drive collision line when the receiving port collides
// - collision line is an input by default so other chips may drive it
// - direction output high exactly while this chip drives expansion lines
// - direction output low whenever not driving, transceiver passes bus inward
// - local activity drive active while own segments receive data or collision
// - local activity sense shows receive activity in this or any chip
// - other activity drive active on transmit collision or multi-port collision
// - other activity sense shows such collisions in this or any chip
// - management clock driven only while receiving, otherwise high impedance
// - management data changes only on falling management clock edges; the code also changes it while a compressed packet holds the clock low
// - management data carries packet bits then status, inactive otherwise
// - management carrier sense driven while receiving, otherwise an input
// - management transceiver enable high while management lines are driven
// - shorten request low during management carrier compresses that packet; the code samples it only while the packet is driven, not in the status tail
// - shorten request held low compresses all, held high compresses none
// - raw encoded receive data of receiving port shown on a test output
// - expansion data changes on falling clock, receivers sample on rising
// - expansion data, frame and clock driven only while receiving
`default_nettype none
package rpx_pkg;
  // main clock rate of this build
  localparam int unsigned SYS_CLK_HZ = 10_000_000;
  // status bits appended to each packet on the management stream
  localparam int unsigned STATUS_BITS = 16;
  // packet bits kept on the management stream when a packet is compressed
  localparam int unsigned COMPRESS_KEEP_BITS = 64;
  // width of words assembled from the expansion bus receiver
  localparam int unsigned LINK_WORD_BITS = 16;
  // reset value of every serial output bit
  localparam logic SERIAL_RESET = 1'b0;

  // gray coded along idle, packet, status
  typedef enum logic [1:0] {
    RPX_IDLE   = 2'b00,
    RPX_PACKET = 2'b01,
    RPX_STATUS = 2'b11
  } rpx_state_e;
endpackage : rpx_pkg
`default_nettype wire

// ==== rtl/rpx_link_if.sv ====
// interface carrying received expansion words from the link domain to the main domain
`default_nettype none
interface rpx_link_if #(
  parameter int unsigned W = rpx_pkg::LINK_WORD_BITS
);
  logic [W-1:0] word;
  logic         word_toggle;
  modport rx  (output word, output word_toggle);
  modport sys (input word, input word_toggle);
endinterface : rpx_link_if
`default_nettype wire

// ==== rtl/rpx_link_rx.sv ====
// expansion bus receiver running on the bus clock of whichever chip drives it
`default_nettype none
module rpx_link_rx #(
  parameter int unsigned W = rpx_pkg::LINK_WORD_BITS
) (
  input  wire logic   link_clk_i,
  input  wire logic   rst_n_i,
  input  wire logic   frame_i,
  input  wire logic   data_i,
  rpx_link_if.rx      link
);
  typedef struct packed {
    logic [W-1:0]         shift;
    logic [$clog2(W)-1:0] cnt;
    logic [W-1:0]         word;
    logic                 toggle;
  } rpx_rx_s;

  rpx_rx_s s;
  rpx_rx_s next_s;

  // rising edge sampling
  // a partial word is dropped when the frame ends; the count restarts on the
  // first edge seen with frame low, so the driver gives one such edge per frame
  always_comb begin
    next_s = s;
    if (frame_i) begin
      next_s.shift = {s.shift[W-2:0], data_i};
      next_s.cnt   = s.cnt + 1'b1;
      if (s.cnt == ($clog2(W))'(W - 1)) begin
        next_s.word   = {s.shift[W-2:0], data_i};
        next_s.toggle = ~s.toggle;
      end
    end else begin
      next_s.cnt = '0;
    end
  end

  // word moves on the same edge as its toggle; the main side copies it only after the toggle synchroniser
  always_ff @(posedge link_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign link.word        = s.word;
  assign link.word_toggle = s.toggle;
endmodule : rpx_link_rx
`default_nettype wire

// ==== dv/rpx_peer.sv ====
// behavioural model of another repeater chip sending one word on the expansion bus
`default_nettype none
module rpx_peer (
  input  wire logic        go_i,
  input  wire logic [15:0] word_i,
  output logic             clk_o,
  output logic             frame_o,
  output logic             data_o
);
  timeunit 1ns;
  timeprecision 1ns;

  // idle: clock parked low, lines released
  initial begin
    clk_o = 1'b0;
    frame_o = 1'b0;
    data_o = 1'b1;
  end

  // one frame at a 30 ns bus clock, msb first, phase unrelated to the main clock
  always @(posedge go_i) begin
    #7;
    for (int i = 15; i >= 0; i--) begin
      clk_o = 1'b0;
      data_o = word_i[i];
      frame_o = 1'b1;
      #15 clk_o = 1'b1;
      #15;
    end
    clk_o = 1'b0;
    frame_o = 1'b0;
    // released line shows a stale inverse so a held bit is never mistaken for data
    data_o = ~data_o;
    // one edge with frame low separates frames, then the clock stands still
    #15 clk_o = 1'b1;
    #15 clk_o = 1'b0;
  end
endmodule : rpx_peer
`default_nettype wire

// ==== dv/repeater_expansion_mgmt_bus_tb_top.sv ====
// self-checking bench for the expansion and management bus pin block
`default_nettype none
module repeater_expansion_mgmt_bus_tb_top;
  timeunit 1ns;
  timeprecision 1ns;

  logic        sys_clk_i, rst_n_i, seg_rx_active_i, seg_rx_bit_i, seg_bit_take_o;
  logic        seg_rx_collision_i, seg_multi_collision_i, seg_tx_collision_i;
  logic        seg_raw_manchester_i, expansion_bus_drive_enable_o;
  logic [15:0] status_word_i, exp_rx_word_o, peer_word;
  logic        receiving_port_collision_i, receiving_port_collision_o;
  logic        receiving_port_collision_oe_o, expansion_serial_data_i;
  logic        expansion_serial_data_o, expansion_serial_data_oe_o;
  logic        expansion_frame_enable_i, expansion_frame_enable_o;
  logic        expansion_frame_enable_oe_o, expansion_bus_clock_i;
  logic        expansion_bus_clock_o, expansion_bus_clock_oe_o;
  logic        local_activity_drive_o, local_activity_drive_oe_o, local_activity_sense_n_i;
  logic        other_activity_drive_o, other_activity_drive_oe_o, other_activity_sense_n_i;
  logic        mgmt_rx_clock_o, mgmt_rx_clock_oe_o, mgmt_carrier_sense_i;
  logic        mgmt_carrier_sense_o, mgmt_carrier_sense_oe_o, mgmt_rx_data_o;
  logic        mgmt_rx_data_oe_o, mgmt_bus_drive_enable_o, packet_shorten_request_n_i;
  logic        raw_encoded_rx_test_out_o, local_activity_seen_o, other_activity_seen_o;
  logic        bus_collision_seen_o, mgmt_carrier_seen_o, packet_compressed_o;
  logic        exp_rx_frame_o, exp_rx_word_valid_o;
  logic        peer_go, peer_clk, peer_frame, peer_data, tb_coll, tb_crs, tb_loc, tb_oth;
  logic        mon_on, m_clk_q, m_dat_q, x_clk_q;
  logic [95:0] pat;
  logic        mq[$];
  logic        xq[$];
  int          takes, fails, total_checks, cycles;

  rpx_bus_ctrl rpx_bus_ctrl_i (
    .sys_clk_i, .rst_n_i, .seg_rx_active_i, .seg_rx_bit_i, .seg_bit_take_o,
    .seg_rx_collision_i, .seg_multi_collision_i, .seg_tx_collision_i, .seg_raw_manchester_i,
    .status_word_i, .receiving_port_collision_i, .receiving_port_collision_o,
    .receiving_port_collision_oe_o, .expansion_serial_data_i, .expansion_serial_data_o,
    .expansion_serial_data_oe_o, .expansion_frame_enable_i, .expansion_frame_enable_o,
    .expansion_frame_enable_oe_o, .expansion_bus_clock_i, .expansion_bus_clock_o,
    .expansion_bus_clock_oe_o, .expansion_bus_drive_enable_o, .local_activity_drive_o,
    .local_activity_drive_oe_o, .local_activity_sense_n_i, .other_activity_drive_o,
    .other_activity_drive_oe_o, .other_activity_sense_n_i, .mgmt_rx_clock_o,
    .mgmt_rx_clock_oe_o, .mgmt_carrier_sense_i, .mgmt_carrier_sense_o,
    .mgmt_carrier_sense_oe_o, .mgmt_rx_data_o, .mgmt_rx_data_oe_o, .mgmt_bus_drive_enable_o,
    .packet_shorten_request_n_i, .raw_encoded_rx_test_out_o, .local_activity_seen_o,
    .other_activity_seen_o, .bus_collision_seen_o, .mgmt_carrier_seen_o,
    .packet_compressed_o, .exp_rx_frame_o, .exp_rx_word_o, .exp_rx_word_valid_o
  );

  rpx_peer rpx_peer_i (
    .go_i(peer_go), .word_i(peer_word), .clk_o(peer_clk), .frame_o(peer_frame),
    .data_o(peer_data)
  );

  // shared wires: whoever enables its driver owns the line
  assign expansion_serial_data_i =
    expansion_serial_data_oe_o ? expansion_serial_data_o : peer_data;
  assign expansion_frame_enable_i =
    expansion_frame_enable_oe_o ? expansion_frame_enable_o : peer_frame;
  assign expansion_bus_clock_i = expansion_bus_clock_oe_o ? expansion_bus_clock_o : peer_clk;
  assign receiving_port_collision_i =
    receiving_port_collision_oe_o ? receiving_port_collision_o : tb_coll;
  assign mgmt_carrier_sense_i = mgmt_carrier_sense_oe_o ? mgmt_carrier_sense_o : tb_crs;
  // open drain activity lines with pull-up, wired with the other chips
  assign local_activity_sense_n_i = ~(local_activity_drive_oe_o | tb_loc);
  assign other_activity_sense_n_i = ~(other_activity_drive_oe_o | tb_oth);

  always #50 sys_clk_i = ~sys_clk_i;

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      fails++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic results();
    $display("checks %0d mismatches %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : results

  // count consumed bits; bound the run so a hang still reaches the report
  always @(posedge sys_clk_i) begin
    if (seg_bit_take_o && seg_rx_active_i) takes <= takes + 1;
    cycles <= cycles + 1;
    if (cycles == 3000) begin
      fails++;
      results();
    end
  end

  // mid-cycle monitor: serial capture and pin ownership, inputs moved here too
  always @(negedge sys_clk_i) begin
    seg_rx_bit_i <= pat[takes];
    if (mon_on) begin
      check(raw_encoded_rx_test_out_o, seg_raw_manchester_i);
      check({receiving_port_collision_oe_o, expansion_serial_data_oe_o,
             expansion_frame_enable_oe_o, expansion_bus_clock_oe_o},
            {4{expansion_bus_drive_enable_o}});
      check({mgmt_rx_clock_oe_o, mgmt_carrier_sense_oe_o, mgmt_rx_data_oe_o},
            {3{mgmt_bus_drive_enable_o}});
      if (mgmt_rx_data_oe_o && mgmt_rx_data_o !== m_dat_q) check(mgmt_rx_clock_o, 1'b0);
      if (mgmt_rx_clock_oe_o && mgmt_rx_clock_o && !m_clk_q) mq.push_back(mgmt_rx_data_o);
      if (expansion_bus_clock_oe_o && expansion_bus_clock_o && !x_clk_q)
        xq.push_back(expansion_serial_data_o);
    end
    seg_raw_manchester_i <= ~seg_raw_manchester_i ^ takes[2];
    m_clk_q <= mgmt_rx_clock_o;
    m_dat_q <= mgmt_rx_data_o;
    x_clk_q <= expansion_bus_clock_o;
  end

  // senses from other chips and the manager while idle; other activity comes from own multi-port collision
  task automatic t_sense();
    @(negedge sys_clk_i);
    {tb_loc, tb_coll, tb_crs, seg_multi_collision_i} = 4'hf;
    repeat (3) @(negedge sys_clk_i);
    check(other_activity_drive_oe_o, 1'b1);
    check({local_activity_seen_o, other_activity_seen_o}, 2'b11);
    check({bus_collision_seen_o, mgmt_carrier_seen_o}, 2'b11);
    {tb_loc, tb_coll, tb_crs, seg_multi_collision_i} = 4'h0;
    repeat (3) @(negedge sys_clk_i);
    check({local_activity_seen_o, other_activity_seen_o, bus_collision_seen_o}, 3'h0);
    $display("sense test done");
  endtask : t_sense

  // one packet of n bits, shorten request held at sh_n throughout
  task automatic t_packet(input int n, input logic sh_n);
    int w;
    int k;
    @(negedge sys_clk_i);
    takes = 0;
    mq.delete();
    xq.delete();
    packet_shorten_request_n_i = sh_n;
    status_word_i = 16'ha5c3 ^ 16'(n);
    {seg_rx_collision_i, seg_tx_collision_i} = 2'b11;
    @(negedge sys_clk_i);
    seg_rx_active_i = 1'b1;
    for (w = 0; takes < n && w < 400; w++) begin
      @(negedge sys_clk_i);
      if (w == 12) begin
        check({receiving_port_collision_o, local_activity_drive_oe_o,
               other_activity_drive_oe_o, local_activity_seen_o}, 4'hf);
        check({mgmt_carrier_sense_o, packet_compressed_o}, {1'b1, ~sh_n});
      end
    end
    {seg_rx_active_i, seg_rx_collision_i, seg_tx_collision_i} = 3'h0;
    for (w = 0; mgmt_bus_drive_enable_o === 1'b1 && w < 100; w++) @(negedge sys_clk_i);
    k = (!sh_n && n > 64) ? 64 : n;
    check(mq.size(), k + rpx_pkg::STATUS_BITS);
    check(xq.size(), n);
    for (int i = 0; i < n; i++) begin
      if (i < k) check(mq[i], pat[i]);
      check(xq[i], pat[i]);
    end
    for (int i = 0; i < 16; i++) check(mq[k + i], status_word_i[15 - i]);
    $display("packet test done, %0d bits", n);
  endtask : t_packet

  // word from another chip crosses from the bus clock domain
  task automatic t_link(input logic [15:0] word);
    int w;
    @(negedge sys_clk_i);
    peer_word = word;
    peer_go = 1'b1;
    repeat (3) @(negedge sys_clk_i);
    check(exp_rx_frame_o, 1'b1);
    for (w = 0; exp_rx_word_valid_o !== 1'b1 && w < 60; w++) @(negedge sys_clk_i);
    check(exp_rx_word_o, word);
    peer_go = 1'b0;
    repeat (4) @(negedge sys_clk_i);
    $display("link test done");
  endtask : t_link

  initial begin
    {sys_clk_i, rst_n_i, seg_rx_active_i, seg_rx_collision_i, seg_multi_collision_i} = '0;
    {seg_tx_collision_i, seg_raw_manchester_i, peer_go, tb_coll, tb_crs, tb_loc} = '0;
    {tb_oth, mon_on, m_clk_q, m_dat_q, x_clk_q, takes, fails, total_checks, cycles} = '0;
    {status_word_i, peer_word} = '0;
    packet_shorten_request_n_i = 1'b1;
    pat = 96'hc3a5_0f96_e1d2_7b48_3c69_f05a;
    repeat (3) @(negedge sys_clk_i);
    check({expansion_bus_drive_enable_o, mgmt_bus_drive_enable_o, mgmt_rx_clock_oe_o,
           receiving_port_collision_oe_o, mgmt_carrier_sense_oe_o}, 5'h0);
    rst_n_i = 1'b1;
    repeat (2) @(negedge sys_clk_i);
    mon_on = 1'b1;
    t_sense();
    t_packet(80, 1'b1);
    t_packet(80, 1'b0);
    t_packet(64, 1'b0);
    t_packet(65, 1'b0);
    t_packet(1, 1'b1);
    t_link(16'h8001);
    t_link(16'h7ffe);
    results();
  end
endmodule : repeater_expansion_mgmt_bus_tb_top
`default_nettype wire
